//--- pkg/fsr_params.svh
/*
 * Constants of the floating point stack register file: register offsets,
 * field positions, tag codes and reset values.
 * Assumes it is included by its bare name, once per compilation unit.
 */
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// --------------------------------------------------------------------
// Register offsets on the AXI4-Lite bus (byte addresses).
// --------------------------------------------------------------------
`define FSR_OFF_TAG 4'h0
`define FSR_OFF_STATUS 4'h4
`define FSR_OFF_IRQ_STAT 4'h8
`define FSR_OFF_IRQ_MASK 4'hC

// --------------------------------------------------------------------
// Status word field positions.
// --------------------------------------------------------------------
`define FSR_SW_BUSY 15
`define FSR_SW_C3 14
`define FSR_SW_TOP_HI 13
`define FSR_SW_TOP_LO 11
`define FSR_SW_C2 10
`define FSR_SW_C1 9
`define FSR_SW_C0 8
`define FSR_SW_ES 7

// --------------------------------------------------------------------
// Tag codes and reset values.
// --------------------------------------------------------------------
`define FSR_TAG_VALID 2'h0
`define FSR_TAG_ZERO 2'h1
`define FSR_TAG_SPECIAL 2'h2
`define FSR_TAG_EMPTY 2'h3
`define FSR_TOP_RESET 3'h0
`define FSR_TAGW_RESET 16'hFFFF
`define FSR_TOP_ONE 3'h1
`define FSR_BRESP_OKAY 2'h0
`define FSR_BRESP_SLVERR 2'h2
`define FSR_IRQ_BITS 4
`define FSR_IRQ_PUSH 0
`define FSR_IRQ_POP 1
`define FSR_IRQ_REM 2
`define FSR_IRQ_ES 3

`endif

//--- pkg/fsr_pkg.sv
/*
 * Types of the floating point stack register file.
 * Assumes fsr_params.svh holds the numeric constants.
 */
package fsr_pkg;

    // ----------------------------------------------------------------
    // Operation codes from the execution pipeline.
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FSR_OP_NONE = 3'b000,
        FSR_OP_PUSH = 3'b001,
        FSR_OP_POP = 3'b010,
        FSR_OP_WRITE = 3'b011,
        FSR_OP_COND = 3'b100,
        FSR_OP_REM = 3'b101,
        FSR_OP_TAG = 3'b110
    } fsr_op_type;

    // ----------------------------------------------------------------
    // One request from the pipeline, valid for one cycle.
    // ----------------------------------------------------------------
    typedef struct packed {
        fsr_op_type op;
        logic [2:0] reg_rel;
        logic [79:0] data;
        logic [1:0] tag;
        logic [3:0] cond;
        logic [2:0] quot;
        logic rem_done;
        logic es;
    } fsr_req_type;

    // ----------------------------------------------------------------
    // Registered answer to the pipeline.
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [79:0] data;
        logic [1:0] tag;
    } fsr_rsp_type;

endpackage

//--- rtl/fsr_stack_regs.sv
/*
 * Floating point stack register file: eight 80-bit data registers, tag
 * word, status word, AXI4-Lite access to tag and status, event interrupt.
 * Assumes one pipeline request per cycle at most, and an AXI4-Lite master
 * holding at most one write and one read under way.
 */
`timescale 1ns/1ns
`include "fsr_params.svh"
module fsr_stack_regs import fsr_pkg::*; (
    input wire logic mclk,
    input wire logic reset,
    input wire fsr_req_type req,
    output fsr_rsp_type rsp,
    output logic [15:0] status_word,
    output logic [15:0] tag_word,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    logic [79:0] data_r [0:7];
    logic [1:0] tag_r [0:7];
    logic [2:0] top_r;
    logic es_r;
    logic c0_r;
    logic c1_r;
    logic c2_r;
    logic c3_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic [3:0] irq_evt;
    logic [2:0] top_nxt;
    logic [2:0] phys_idx;
    logic [15:0] sw_nxt;
    logic [15:0] tw_nxt;
    logic aw_held_r;
    logic w_held_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic wr_mapped;

    // Explicit register numbers are relative to top and wrap in three bits.
    assign phys_idx = top_r + req.reg_rel;

    // Push moves top down before the write; pop moves it up after the read.
    always_comb begin
        top_nxt = top_r;
        if (req.op == FSR_OP_PUSH) begin
            top_nxt = top_r - `FSR_TOP_ONE;
        end else if (req.op == FSR_OP_POP) begin
            top_nxt = top_r + `FSR_TOP_ONE;
        end
    end

    // ----------------------------------------------------------------
    // Stack pointer.
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            top_r <= `FSR_TOP_RESET;
        end else begin
            top_r <= top_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Data registers and tags, one slice per register.
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_reg
            // A pushed value lands in the register selected by the new top.
            always_ff @(posedge mclk) begin
                if (reset) begin
                    data_r[gi] <= 80'h0;
                    tag_r[gi] <= `FSR_TAG_EMPTY;
                end else if (req.op == FSR_OP_PUSH && top_nxt == 3'(gi)) begin
                    data_r[gi] <= req.data;
                    tag_r[gi] <= req.tag;
                end else if (req.op == FSR_OP_WRITE && phys_idx == 3'(gi)) begin
                    data_r[gi] <= req.data;
                    tag_r[gi] <= req.tag;
                end else if (req.op == FSR_OP_TAG && phys_idx == 3'(gi)) begin
                    tag_r[gi] <= req.tag;
                end else if (req.op == FSR_OP_POP && top_r == 3'(gi)) begin
                    tag_r[gi] <= `FSR_TAG_EMPTY;
                end
            end
            assign tw_nxt[2*gi+1:2*gi] = tag_r[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read answer: pop returns the old top, others the addressed register.
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp <= '0;
        end else begin
            rsp.valid <= (req.op != FSR_OP_NONE);
            if (req.op == FSR_OP_POP) begin
                rsp.data <= data_r[top_r];
                rsp.tag <= tag_r[top_r];
            end else begin
                rsp.data <= data_r[phys_idx];
                rsp.tag <= tag_r[phys_idx];
            end
        end
    end

    // ----------------------------------------------------------------
    // Condition bits and error summary.
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            c0_r <= 1'b0;
            c1_r <= 1'b0;
            c2_r <= 1'b0;
            c3_r <= 1'b0;
            es_r <= 1'b0;
        end else begin
            es_r <= req.es;
            if (req.op == FSR_OP_COND) begin
                {c3_r, c2_r, c1_r, c0_r} <= req.cond;
            end else if (req.op == FSR_OP_REM) begin
                c0_r <= req.quot[2];
                c3_r <= req.quot[0];
                c1_r <= req.quot[1];
                // Pipeline flags done only when remainder fell below modulus.
                c2_r <= ~req.rem_done;
            end
        end
    end

    // Status word assembly; busy mirrors the error summary.
    always_comb begin
        sw_nxt = '0;
        sw_nxt[`FSR_SW_BUSY] = es_r;
        sw_nxt[`FSR_SW_ES] = es_r;
        sw_nxt[`FSR_SW_TOP_HI:`FSR_SW_TOP_LO] = top_r;
        sw_nxt[`FSR_SW_C3] = c3_r;
        sw_nxt[`FSR_SW_C2] = c2_r;
        sw_nxt[`FSR_SW_C1] = c1_r;
        sw_nxt[`FSR_SW_C0] = c0_r;
    end

    // Registered copies so the outputs come straight from flip-flops.
    always_ff @(posedge mclk) begin
        if (reset) begin
            status_word <= '0;
            tag_word <= `FSR_TAGW_RESET;
        end else begin
            status_word <= sw_nxt;
            tag_word <= tw_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status: sticky, write one to clear, set beats clear.
    // ----------------------------------------------------------------
    assign irq_evt[`FSR_IRQ_PUSH] = (req.op == FSR_OP_PUSH);
    assign irq_evt[`FSR_IRQ_POP] = (req.op == FSR_OP_POP);
    assign irq_evt[`FSR_IRQ_REM] = (req.op == FSR_OP_REM) && !req.rem_done;
    assign irq_evt[`FSR_IRQ_ES] = req.es && !es_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_stat_r <= '0;
        end else if (wr_fire && awaddr_r == `FSR_OFF_IRQ_STAT && wstrb_r[0]) begin
            irq_stat_r <= (irq_stat_r & ~wdata_r[3:0]) | irq_evt;
        end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_mask_r <= '0;
        end else if (wr_fire && awaddr_r == `FSR_OFF_IRQ_MASK && wstrb_r[0]) begin
            irq_mask_r <= wdata_r[3:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write: address and data taken in either order.
    // ----------------------------------------------------------------
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_mapped = (awaddr_r == `FSR_OFF_TAG) || (awaddr_r == `FSR_OFF_STATUS) ||
                       (awaddr_r == `FSR_OFF_IRQ_STAT) || (awaddr_r == `FSR_OFF_IRQ_MASK);

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FSR_BRESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `FSR_BRESP_OKAY : `FSR_BRESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read. Tag and status words are read only; the pipeline
    // owns them, so software writes there are accepted and ignored.
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `FSR_BRESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `FSR_BRESP_OKAY;
                unique case (s_axi_araddr)
                    `FSR_OFF_TAG: s_axi_rdata <= {16'h0000, tw_nxt};
                    `FSR_OFF_STATUS: s_axi_rdata <= {16'h0000, sw_nxt};
                    `FSR_OFF_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_r};
                    `FSR_OFF_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask_r};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= `FSR_BRESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

//--- verif/fsr_stack_regs_checker.sv
/*
 * Port checker of the stack register file: request answers, status fields, AXI4-Lite answers.
 * Assumes fsr_pkg is compiled first; attached to the block by the bind at the foot.
 */
`timescale 1ns/1ns
module fsr_stack_regs_checker import fsr_pkg::*; (
    input wire logic mclk,
    input wire logic reset,
    input wire fsr_req_type req,
    input wire fsr_rsp_type rsp,
    input wire logic [15:0] status_word,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // The status word trails the state by one cycle, so effects show two edges on.
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_busy_mirror; status_word[15] == status_word[7]; endproperty
    a_busy_mirror: assert property (p_busy_mirror) else $error("busy bit differs from summary");
    property p_es_track; !$past(reset) && !$past(reset, 2) |-> status_word[7] == $past(req.es, 2); endproperty
    a_es_track: assert property (p_es_track) else $error("error summary not tracked");
    property p_rsp_pulse; req.op != FSR_OP_NONE |=> rsp.valid; endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("request left unanswered");
    property p_rsp_idle; req.op == FSR_OP_NONE |=> !rsp.valid; endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("answer without request");
    property p_push_top;
        req.op == FSR_OP_PUSH |=> ##1 status_word[13:11] == $past(status_word[13:11]) - 3'h1;
    endproperty
    a_push_top: assert property (p_push_top) else $error("push did not lower top");
    property p_pop_top;
        req.op == FSR_OP_POP |=> ##1 status_word[13:11] == $past(status_word[13:11]) + 3'h1;
    endproperty
    a_pop_top: assert property (p_pop_top) else $error("pop did not raise top");
    property p_rem_code;
        req.op == FSR_OP_REM |=> ##1 status_word[8] == $past(req.quot[2], 2)
            && status_word[14] == $past(req.quot[0], 2)
            && status_word[9] == $past(req.quot[1], 2) && status_word[10] == !$past(req.rem_done, 2);
    endproperty
    a_rem_code: assert property (p_rem_code) else $error("remainder condition bits wrong");
    property p_cond_load;
        req.op == FSR_OP_COND |=> ##1 {status_word[14], status_word[10:8]} == $past(req.cond, 2);
    endproperty
    a_cond_load: assert property (p_cond_load) else $error("condition bits not loaded");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data late");
    property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_drop: assert property (p_r_drop) else $error("read data not withdrawn");
    property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_drop: assert property (p_b_drop) else $error("write response not withdrawn");
    c_push: cover property (req.op == FSR_OP_PUSH);
    c_rem_open: cover property (req.op == FSR_OP_REM && !req.rem_done);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind fsr_stack_regs fsr_stack_regs_checker u_chk (.mclk(mclk), .reset(reset), .req(req), .rsp(rsp),
    .status_word(status_word), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready));

//--- verif/fsr_pipe_model.sv
/*
 * Pipeline model: launches one bench command as a one-cycle request and drives the error summary level.
 * Assumes the bench changes cmd and cmd_valid just after a rising edge.
 */
`timescale 1ns/1ns
module fsr_pipe_model import fsr_pkg::*; (
    input wire logic mclk,
    input wire logic reset,
    input wire fsr_req_type cmd,
    input wire logic cmd_valid,
    input wire logic es_level,
    output fsr_req_type req
);
    // Idle cycles flip the data lines so stale operands are never mistaken for live ones.
    always_ff @(posedge mclk) begin
        if (reset) begin
            req <= '0;
        end else if (cmd_valid) begin
            req <= {cmd[96:1], es_level};
        end else begin
            req <= {FSR_OP_NONE, req.reg_rel, ~req.data, req[10:1], es_level};
        end
    end
endmodule

//--- verif/fsr_stack_regs_tb.sv
/*
 * Self-checking bench: pipeline traffic through the model, registers through an AXI4-Lite master task.
 * Assumes the package, constants header, model and checker are compiled first.
 */
`timescale 1ns/1ns
`include "fsr_params.svh"
module fsr_stack_regs_tb import fsr_pkg::*;;
    localparam logic [79:0] D1 = 80'h3FFF8000000000000000;
    localparam logic [79:0] D2 = 80'hC000C90FDAA22168C235;
    localparam logic [79:0] D3 = 80'h7FFFC000000000000000;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic es_level = 1'b0;
    fsr_req_type cmd = '0;
    fsr_req_type req;
    fsr_rsp_type rsp, got;
    logic [15:0] status_word, tag_word;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd_data;
    int fails = 0;
    int checked = 0;
    // 100 MHz clock.
    always #5 mclk = ~mclk;
    fsr_stack_regs uut (.mclk(mclk), .reset(reset), .req(req), .rsp(rsp), .status_word(status_word),
        .tag_word(tag_word), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
    fsr_pipe_model u_pipe (.mclk(mclk), .reset(reset), .cmd(cmd), .cmd_valid(cmd_valid), .es_level(es_level),
        .req(req));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checked %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    function automatic fsr_req_type mk(fsr_op_type op, logic [2:0] rel, logic [79:0] d, logic [1:0] t,
        logic [3:0] c, logic [2:0] q, logic dn);
        return {op, rel, d, t, c, q, dn, 1'b0};
    endfunction
    // Returns one edge after the status word has taken the request's effect.
    task automatic pipe(input fsr_req_type r);
        int n;
        @(posedge mclk);
        cmd <= r;
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin @(posedge mclk); n++; end while (rsp.valid !== 1'b1 && n < 8);
        got = rsp;
        if (rsp.valid !== 1'b1) begin fails++; results(); end
        @(posedge mclk);
    endtask
    // One AXI4-Lite access; each channel drops its valid at the edge that takes it.
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (wr ? s_axi_bvalid : s_axi_rvalid) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        resp = wr ? s_axi_bresp : s_axi_rresp;
        rd_data = s_axi_rdata;
        if (n == 50) begin fails++; results(); end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        chk(tag_word, `FSR_TAGW_RESET);
        chk(status_word, 16'h0000);
        acc(1'b0, `FSR_OFF_TAG, 32'h0);
        chk(rd_data, 32'h0000FFFF);
        acc(1'b0, 4'h2, 32'h0);
        chk({resp, rd_data}, {`FSR_BRESP_SLVERR, 32'h0});
        acc(1'b1, `FSR_OFF_STATUS, 32'hFFFF);
        chk(resp, `FSR_BRESP_OKAY);
        acc(1'b1, 4'h2, 32'h0);
        chk(resp, `FSR_BRESP_SLVERR);
        acc(1'b0, `FSR_OFF_STATUS, 32'h0);
        chk({resp, rd_data}, {`FSR_BRESP_OKAY, 32'h0});
        acc(1'b0, `FSR_OFF_IRQ_MASK, 32'h0);
        chk(rd_data, 32'h0);
        pipe(mk(FSR_OP_PUSH, 3'h0, D1, `FSR_TAG_VALID, 4'h0, 3'h0, 1'b0));
        chk(status_word, 16'h3800);
        pipe(mk(FSR_OP_PUSH, 3'h0, D2, `FSR_TAG_ZERO, 4'h0, 3'h0, 1'b0));
        chk({status_word, tag_word}, {16'h3000, 16'h1FFF});
        pipe(mk(FSR_OP_COND, 3'h1, 80'h0, 2'h0, 4'hA, 3'h0, 1'b0));
        chk({got.data, got.tag, status_word}, {D1, `FSR_TAG_VALID, 16'h7200});
        pipe(mk(FSR_OP_WRITE, 3'h1, D3, `FSR_TAG_SPECIAL, 4'h0, 3'h0, 1'b0));
        pipe(mk(FSR_OP_COND, 3'h1, 80'h0, 2'h0, 4'h0, 3'h0, 1'b0));
        chk({got.data, got.tag}, {D3, `FSR_TAG_SPECIAL});
        pipe(mk(FSR_OP_COND, 3'h2, 80'h0, 2'h0, 4'h0, 3'h0, 1'b0));
        chk(got.tag, `FSR_TAG_EMPTY);
        pipe(mk(FSR_OP_POP, 3'h0, 80'h0, 2'h0, 4'h0, 3'h0, 1'b0));
        chk({got.data, got.tag, status_word}, {D2, `FSR_TAG_ZERO, 16'h3800});
        pipe(mk(FSR_OP_POP, 3'h0, 80'h0, 2'h0, 4'h0, 3'h0, 1'b0));
        chk({got.data, status_word, tag_word}, {D3, 16'h0000, 16'hFFFF});
        for (int q = 0; q < 8; q++) begin
            for (int dn = 0; dn < 2; dn++) begin
                pipe(mk(FSR_OP_REM, 3'h0, 80'h0, 2'h0, 4'h0, q[2:0], dn[0]));
                chk(status_word, {1'b0, q[0], 3'h0, ~dn[0], q[1], q[2], 8'h00});
            end
        end
        // Tag-only update of a register three above top, which sits at zero here.
        pipe(mk(FSR_OP_TAG, 3'h3, 80'h0, `FSR_TAG_ZERO, 4'h0, 3'h0, 1'b0));
        chk(tag_word, 16'hFF7F);
        @(posedge mclk);
        es_level <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({status_word[15], status_word[7]}, 2'b11);
        acc(1'b0, `FSR_OFF_IRQ_STAT, 32'h0);
        chk({irq, rd_data}, {1'b0, 32'h0000000F});
        acc(1'b1, `FSR_OFF_IRQ_MASK, 32'h4);
        acc(1'b0, `FSR_OFF_IRQ_MASK, 32'h0);
        chk({irq, rd_data}, {1'b1, 32'h00000004});
        acc(1'b1, `FSR_OFF_IRQ_STAT, 32'hF);
        acc(1'b0, `FSR_OFF_IRQ_STAT, 32'h0);
        chk({irq, rd_data}, {1'b0, 32'h0});
        results();
    end
endmodule
